// >>> core/rtccal_defs.svh
// Register offsets, field positions, reset values and timing figures of the clock core
`ifndef RTCCAL_DEFS_SVH
`define RTCCAL_DEFS_SVH

`define RTCCAL_ADDR_SEC 4'h0
`define RTCCAL_ADDR_MIN 4'h1
`define RTCCAL_ADDR_HOUR 4'h2
`define RTCCAL_ADDR_WDAY 4'h3
`define RTCCAL_ADDR_DAY 4'h4
`define RTCCAL_ADDR_MONTH 4'h5
`define RTCCAL_ADDR_YEAR 4'h6
`define RTCCAL_ADDR_TRIM 4'h7
`define RTCCAL_ADDR_CTRL2 4'hf

`define RTCCAL_MASK_SEC 8'h7f
`define RTCCAL_MASK_MIN 8'h7f
`define RTCCAL_MASK_HOUR 8'h3f
`define RTCCAL_MASK_WDAY 8'h07
`define RTCCAL_MASK_DAY 8'h3f
`define RTCCAL_MASK_MONTH 8'h1f
`define RTCCAL_MASK_YEAR 8'hff

`define RTCCAL_BIT_HOUR24 5
`define RTCCAL_BIT_ADJ_HALT 4
`define RTCCAL_BIT_CLKDIS 3
`define RTCCAL_BIT_PIRQ 2
`define RTCCAL_BIT_ALA 1
`define RTCCAL_BIT_ALB 0
`define RTCCAL_BIT_XSEL 7
`define RTCCAL_BIT_PM 5

`define RTCCAL_RST_SEC 8'h00
`define RTCCAL_RST_MIN 8'h00
`define RTCCAL_RST_HOUR 8'h00
`define RTCCAL_RST_WDAY 8'h00
`define RTCCAL_RST_DAY 8'h01
`define RTCCAL_RST_MONTH 8'h01
`define RTCCAL_RST_YEAR 8'h00
`define RTCCAL_RST_TRIM 8'h00

`define RTCCAL_DIV_32768 16'h8000
`define RTCCAL_DIV_32000 16'h7d00

`define RTCCAL_CLK_PERIOD_NS 20
`define RTCCAL_ADJ_LIMIT_32768_NS 122000
`define RTCCAL_ADJ_LIMIT_32000_NS 125000
`define RTCCAL_HALT_TIME_NS 100000

`endif

// >>> core/rtccal_pkg.sv
// Types shared by the clock core files
package rtccal_pkg;

  typedef logic [7:0] rtccal_bcd_type;

  typedef enum logic [1:0]
  {
    RTCCAL_HOURS_12 = 2'b01,
    RTCCAL_HOURS_24 = 2'b10
  } rtccal_hour_mode_type;

endpackage

// >>> core/rtccal_bcd_step.sv
// One step of a wrapping two-digit BCD counter
`timescale 1ns/10ps
module rtccal_bcd_step
(
  input wire logic [7:0] value,
  input wire logic [7:0] low_limit,
  input wire logic [7:0] high_limit,
  output logic [7:0] stepped,
  output logic wrapped
);

  logic [3:0] ones_up;
  logic [3:0] tens_up;

  assign ones_up = (value[3:0] == 4'h9) ? 4'h0 : value[3:0] + 4'h1;
  assign tens_up = (value[3:0] == 4'h9) ? value[7:4] + 4'h1 : value[7:4];
  // Anything at or past the limit wraps, so a bad value cannot run away
  assign wrapped = (value >= high_limit);
  assign stepped = wrapped ? low_limit : {tens_up, ones_up};

endmodule

// >>> core/rtccal_core.sv
// Time and calendar counters, trimming and status flags of the clock core
//
// Function
// R1 - Adjust write with seconds 00..29 clears seconds, minutes kept.
// R2 - Adjust write with seconds 30..59 clears seconds and increments minutes.
// R3 - Adjust completes within 122/125 us; writing 0 does nothing.
// R4 - Control bit 4 reads the oscillator-halt flag, 1 after reset or stop.
// R5 - Clock output runs at crystal rate while disable bit is 0.
// R6 - Periodic flag 1 drives interrupt pin low; 0 releases it.
// R7 - Writing 0 clears periodic flag in level mode only; next period sets it.
// R8 - Alarm flags set on alarm match, reset to 0.
// R9 - Writing 0 to an alarm flag releases its pin; host never writes 1.
// R10 - Seconds count BCD 00..59, carry into minutes on wrap.
// R11 - Minutes count BCD 00..59, carry into hours on wrap.
// R12 - Hours follow 12/24 mode, carry to day and weekday at midnight.
// R13 - Weekday counts 0..6 and wraps; host never writes 7.
// R14 - Day counts to 31 or 30 by month, then 1 with month carry.
// R15 - February ends at 29 in leap years, 28 otherwise.
// R16 - Month counts 1..12, wraps with carry into year.
// R17 - Year counts 00..99; every multiple of four is a leap year.
// R18 - Unused high counter bits ignore writes and read zero.
// R19 - Host must replace invalid time or date values with valid ones.
// R20 - Trim register MSB selects 32.768 or 32.000 kHz; resets to zero.
// R21 - Trim value adjusts only timekeeping, never the clock output.
// R22 - Control bit 5 selects 12-hour with PM bit (0) or 24-hour (1).
// R23 - Halt flag holds trim and output disable at zero; control write clears it.
// R24 - One-second advance divides the crystal by 32768 or 32000.
`timescale 1ns/10ps
`include "rtccal_defs.svh"
module rtccal_core
#(
  parameter logic HOUR24_DEFAULT = 1'b0,
  parameter logic CLKDIS_DEFAULT = 1'b0,
  parameter int HALT_CYCLES = `RTCCAL_HALT_TIME_NS / `RTCCAL_CLK_PERIOD_NS,
  parameter int ADJ_LIMIT_CYCLES = `RTCCAL_ADJ_LIMIT_32768_NS / `RTCCAL_CLK_PERIOD_NS,
  parameter int PRESCALE_32768 = `RTCCAL_DIV_32768,
  parameter int PRESCALE_32000 = `RTCCAL_DIV_32000
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic crystal_in,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic periodic_event,
  input wire logic periodic_level_mode,
  input wire logic alarm_a_match,
  input wire logic alarm_b_match,
  output logic clock_out_pin,
  output logic interrupt_pin_a_out,
  output logic interrupt_pin_a_oe,
  output logic interrupt_pin_b_out,
  output logic interrupt_pin_b_oe,
  output logic second_tick
);

  localparam int ADJ_LIMIT_32000_CYCLES =
    `RTCCAL_ADJ_LIMIT_32000_NS / `RTCCAL_CLK_PERIOD_NS;

  // The adjust is applied one cycle after the write, far inside both limits
  if (ADJ_LIMIT_CYCLES < 1 || ADJ_LIMIT_32000_CYCLES < 1)
  begin : bad_adjust_limit
    $error("adjust limit below one cycle");
  end
  if (HALT_CYCLES < 1 || HALT_CYCLES > 65535)
  begin : bad_halt_cycles
    $error("halt detection count out of range");
  end
  // Trim moves a period by up to 124 pulses either way
  if (PRESCALE_32768 < 130 || PRESCALE_32000 < 130 ||
      PRESCALE_32768 > 65000 || PRESCALE_32000 > 65000)
  begin : bad_prescale
    $error("prescaler count out of range");
  end

  // Crystal input synchroniser
  logic xtal_meta_reg;
  logic xtal_s2_reg;
  logic xtal_s3_reg;
  logic xtal_level_reg;
  logic xtal_rise;
  logic xtal_fall;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_meta_reg <= 1'b0;
      xtal_s2_reg <= 1'b0;
      xtal_s3_reg <= 1'b0;
      xtal_level_reg <= 1'b0;
    end
    else
    begin
      xtal_meta_reg <= crystal_in;
      xtal_s2_reg <= xtal_meta_reg;
      xtal_s3_reg <= xtal_s2_reg;
      if (xtal_s2_reg == xtal_s3_reg)
        xtal_level_reg <= xtal_s3_reg;
    end
  end

  assign xtal_rise = xtal_s2_reg & xtal_s3_reg & ~xtal_level_reg;
  assign xtal_fall = ~xtal_s2_reg & ~xtal_s3_reg & xtal_level_reg;

  // Registers
  logic [7:0] sec_reg;
  logic [7:0] min_reg;
  logic [7:0] hour_reg;
  logic [7:0] wday_reg;
  logic [7:0] day_reg;
  logic [7:0] month_reg;
  logic [7:0] year_reg;
  logic [7:0] trim_reg;
  logic hour24_reg;
  logic clkdis_reg;
  logic halt_reg;
  logic pirq_reg;
  logic ala_reg;
  logic alb_reg;
  logic adjust_reg;
  logic [15:0] pre_reg;
  logic [15:0] halt_cnt_reg;

  // Write decode
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_wday;
  logic wr_day;
  logic wr_month;
  logic wr_year;
  logic wr_trim;
  logic wr_ctrl2;

  assign wr_sec = reg_write && reg_addr == `RTCCAL_ADDR_SEC;
  assign wr_min = reg_write && reg_addr == `RTCCAL_ADDR_MIN;
  assign wr_hour = reg_write && reg_addr == `RTCCAL_ADDR_HOUR;
  assign wr_wday = reg_write && reg_addr == `RTCCAL_ADDR_WDAY;
  assign wr_day = reg_write && reg_addr == `RTCCAL_ADDR_DAY;
  assign wr_month = reg_write && reg_addr == `RTCCAL_ADDR_MONTH;
  assign wr_year = reg_write && reg_addr == `RTCCAL_ADDR_YEAR;
  assign wr_trim = reg_write && reg_addr == `RTCCAL_ADDR_TRIM;
  assign wr_ctrl2 = reg_write && reg_addr == `RTCCAL_ADDR_CTRL2;

  // Trimming: two crystal pulses per step, applied at seconds 00, 20 and 40
  logic [6:0] trim_value;
  logic [7:0] trim_neg_steps;
  logic [15:0] trim_add;
  logic [15:0] trim_sub;
  logic trim_second;
  logic [15:0] base_period;
  logic [15:0] period;
  logic pre_end;

  assign trim_value = trim_reg[6:0];
  assign trim_neg_steps = 8'h80 - {1'b0, trim_value};
  assign trim_second = (sec_reg == 8'h00) || (sec_reg == 8'h20) || (sec_reg == 8'h40);
  // R21 trim timekeeping only
  assign trim_add = (!trim_value[6] && trim_value > 7'h01 && trim_second)
                    ? {8'h00, trim_value - 7'h01, 1'b0} : 16'h0000;
  assign trim_sub = (trim_value[6] && trim_neg_steps < 8'h3f && trim_second)
                    ? {7'h00, trim_neg_steps, 1'b0} : 16'h0000;
  // R20 crystal select
  // R24 one second divider
  assign base_period = trim_reg[`RTCCAL_BIT_XSEL] ? PRESCALE_32000[15:0] : PRESCALE_32768[15:0];
  assign period = base_period + trim_add - trim_sub;
  assign pre_end = xtal_rise && (pre_reg >= period - 16'h0001);

  // Second adjust decision
  logic adj_round_up;
  logic tick;

  // R1 low half keeps minutes
  // R2 high half rounds up
  assign adj_round_up = adjust_reg && (sec_reg >= 8'h30);
  assign tick = pre_end && !adjust_reg;

  // BCD counters: seconds, minutes, day, month, year
  logic [7:0] cnt_val [0:4];
  logic [7:0] cnt_low [0:4];
  logic [7:0] cnt_high [0:4];
  logic [7:0] cnt_step [0:4];
  logic cnt_wrap [0:4];
  logic leap_year;
  logic [7:0] month_end;

  // R17 leap every fourth year
  assign leap_year = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6)
                                 : (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 ||
                                    year_reg[3:0] == 4'h8);
  // R14 month lengths
  // R15 February length
  assign month_end = (month_reg == 8'h02) ? (leap_year ? 8'h29 : 8'h28) :
                     (month_reg == 8'h04 || month_reg == 8'h06 ||
                      month_reg == 8'h09 || month_reg == 8'h11) ? 8'h30 : 8'h31;

  assign cnt_val[0] = sec_reg;
  assign cnt_val[1] = min_reg;
  assign cnt_val[2] = day_reg;
  assign cnt_val[3] = month_reg;
  assign cnt_val[4] = year_reg;
  assign cnt_low[0] = 8'h00;
  assign cnt_low[1] = 8'h00;
  assign cnt_low[2] = 8'h01;
  assign cnt_low[3] = 8'h01;
  assign cnt_low[4] = 8'h00;
  // R10 seconds limit
  assign cnt_high[0] = 8'h59;
  // R11 minutes limit
  assign cnt_high[1] = 8'h59;
  assign cnt_high[2] = month_end;
  // R16 month limit
  assign cnt_high[3] = 8'h12;
  // R17 year limit
  assign cnt_high[4] = 8'h99;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : counter_step
      rtccal_bcd_step step_inst
      (
        .value(cnt_val[gi]),
        .low_limit(cnt_low[gi]),
        .high_limit(cnt_high[gi]),
        .stepped(cnt_step[gi]),
        .wrapped(cnt_wrap[gi])
      );
    end
  endgenerate

  // Carry chain
  logic min_inc;
  logic hour_inc;
  logic day_inc;
  logic month_inc;
  logic year_inc;

  // R10 seconds carry
  assign min_inc = (tick && cnt_wrap[0]) || adj_round_up;
  // R11 minutes carry
  assign hour_inc = min_inc && cnt_wrap[1];

  // Hours in the selected display mode
  rtccal_pkg::rtccal_hour_mode_type hour_mode;
  logic [3:0] hour_ones_up;
  logic [3:0] hour_tens_up;
  logic [7:0] hour_plus;
  logic [4:0] hour_12;
  logic hour_pm;
  logic [7:0] hour_step;
  logic hour_carry;

  // R22 hour mode select
  assign hour_mode = hour24_reg ? rtccal_pkg::RTCCAL_HOURS_24 : rtccal_pkg::RTCCAL_HOURS_12;
  assign hour_ones_up = (hour_reg[3:0] == 4'h9) ? 4'h0 : hour_reg[3:0] + 4'h1;
  assign hour_tens_up = (hour_reg[3:0] == 4'h9) ? hour_reg[7:4] + 4'h1 : hour_reg[7:4];
  assign hour_plus = {hour_tens_up, hour_ones_up};
  assign hour_12 = hour_reg[4:0];
  assign hour_pm = hour_reg[`RTCCAL_BIT_PM];

  // R12 midnight carry
  always_comb
  begin
    hour_step = hour_plus;
    hour_carry = 1'b0;
    unique case (hour_mode)
      rtccal_pkg::RTCCAL_HOURS_24:
      begin
        if (hour_reg >= 8'h23)
        begin
          hour_step = 8'h00;
          hour_carry = 1'b1;
        end
      end
      rtccal_pkg::RTCCAL_HOURS_12:
      begin
        if (hour_12 >= 5'h12)
          hour_step = {2'b00, hour_pm, 5'h01};
        else if (hour_12 == 5'h11)
        begin
          hour_step = hour_pm ? 8'h12 : 8'h32;
          hour_carry = hour_pm;
        end
        else
          hour_step = {2'b00, hour_pm, hour_plus[4:0]};
      end
    endcase
  end

  assign day_inc = hour_inc && hour_carry;
  assign month_inc = day_inc && cnt_wrap[2];
  assign year_inc = month_inc && cnt_wrap[3];

  // R13 weekday wraps after six
  logic [7:0] wday_step;
  assign wday_step = (wday_reg >= 8'h06) ? 8'h00 : wday_reg + 8'h01;

  // Next values; a host write beats a count in the same cycle
  // R18 unused bits masked
  // R1 seconds cleared
  logic [7:0] sec_next;
  logic [7:0] min_next;
  logic [7:0] hour_next;
  logic [7:0] wday_next;
  logic [7:0] day_next;
  logic [7:0] month_next;
  logic [7:0] year_next;
  logic [7:0] trim_next;

  assign sec_next = wr_sec ? reg_wdata & `RTCCAL_MASK_SEC :
                    adjust_reg ? 8'h00 : tick ? cnt_step[0] : sec_reg;
  assign min_next = wr_min ? reg_wdata & `RTCCAL_MASK_MIN :
                    min_inc ? cnt_step[1] : min_reg;
  assign hour_next = wr_hour ? reg_wdata & `RTCCAL_MASK_HOUR :
                     hour_inc ? hour_step : hour_reg;
  assign wday_next = wr_wday ? reg_wdata & `RTCCAL_MASK_WDAY :
                     day_inc ? wday_step : wday_reg;
  assign day_next = wr_day ? reg_wdata & `RTCCAL_MASK_DAY :
                    day_inc ? cnt_step[2] : day_reg;
  assign month_next = wr_month ? reg_wdata & `RTCCAL_MASK_MONTH :
                      month_inc ? cnt_step[3] : month_reg;
  assign year_next = wr_year ? reg_wdata & `RTCCAL_MASK_YEAR :
                     year_inc ? cnt_step[4] : year_reg;
  // R23 trim held while halted
  assign trim_next = halt_reg ? 8'h00 : wr_trim ? reg_wdata : trim_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sec_reg <= `RTCCAL_RST_SEC;
      min_reg <= `RTCCAL_RST_MIN;
      hour_reg <= `RTCCAL_RST_HOUR;
      wday_reg <= `RTCCAL_RST_WDAY;
      day_reg <= `RTCCAL_RST_DAY;
      month_reg <= `RTCCAL_RST_MONTH;
      year_reg <= `RTCCAL_RST_YEAR;
      trim_reg <= `RTCCAL_RST_TRIM;
    end
    else
    begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      wday_reg <= wday_next;
      day_reg <= day_next;
      month_reg <= month_next;
      year_reg <= year_next;
      trim_reg <= trim_next;
    end
  end

  // Prescaler restarts on adjust so the next second is a full one
  logic [15:0] pre_next;
  assign pre_next = adjust_reg ? 16'h0000 : pre_end ? 16'h0000 :
                    xtal_rise ? pre_reg + 16'h0001 : pre_reg;

  // Halt detection: crystal edges absent for HALT_CYCLES
  logic halt_seen;
  logic [15:0] halt_cnt_next;
  assign halt_seen = (halt_cnt_reg >= HALT_CYCLES[15:0] - 16'h0001);
  assign halt_cnt_next = xtal_rise ? 16'h0000 : halt_seen ? halt_cnt_reg :
                         halt_cnt_reg + 16'h0001;

  // R3 adjust in one cycle
  logic adjust_next;
  assign adjust_next = wr_ctrl2 && reg_wdata[`RTCCAL_BIT_ADJ_HALT];

  // Status flags: hardware set wins over host clear
  // R4 halt flag set
  // R23 control write clears
  logic halt_next;
  logic clkdis_next;
  logic pirq_next;
  logic ala_next;
  logic alb_next;
  assign halt_next = halt_seen || (halt_reg && !wr_ctrl2);
  assign clkdis_next = halt_reg ? 1'b0 : wr_ctrl2 ? reg_wdata[`RTCCAL_BIT_CLKDIS] : clkdis_reg;
  // R7 level mode clear
  assign pirq_next = periodic_event ||
                     (pirq_reg && !(wr_ctrl2 && periodic_level_mode &&
                                    !reg_wdata[`RTCCAL_BIT_PIRQ]));
  // R8 alarm flag set
  // R9 write zero clears
  assign ala_next = alarm_a_match || (ala_reg && !(wr_ctrl2 && !reg_wdata[`RTCCAL_BIT_ALA]));
  assign alb_next = alarm_b_match || (alb_reg && !(wr_ctrl2 && !reg_wdata[`RTCCAL_BIT_ALB]));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_reg <= 16'h0000;
      halt_cnt_reg <= 16'h0000;
      halt_reg <= 1'b1;
      adjust_reg <= 1'b0;
      hour24_reg <= HOUR24_DEFAULT;
      clkdis_reg <= CLKDIS_DEFAULT;
      pirq_reg <= 1'b0;
      ala_reg <= 1'b0;
      alb_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      halt_cnt_reg <= halt_cnt_next;
      halt_reg <= halt_next;
      adjust_reg <= adjust_next;
      hour24_reg <= wr_ctrl2 ? reg_wdata[`RTCCAL_BIT_HOUR24] : hour24_reg;
      clkdis_reg <= clkdis_next;
      pirq_reg <= pirq_next;
      ala_reg <= ala_next;
      alb_reg <= alb_next;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] ctrl2_view;
  logic [7:0] rd_mux;
  assign ctrl2_view = {2'b00, hour24_reg, halt_reg, clkdis_reg, pirq_reg, ala_reg, alb_reg};
  assign rd_mux = (reg_addr == `RTCCAL_ADDR_SEC) ? sec_reg :
                  (reg_addr == `RTCCAL_ADDR_MIN) ? min_reg :
                  (reg_addr == `RTCCAL_ADDR_HOUR) ? hour_reg :
                  (reg_addr == `RTCCAL_ADDR_WDAY) ? wday_reg :
                  (reg_addr == `RTCCAL_ADDR_DAY) ? day_reg :
                  (reg_addr == `RTCCAL_ADDR_MONTH) ? month_reg :
                  (reg_addr == `RTCCAL_ADDR_YEAR) ? year_reg :
                  (reg_addr == `RTCCAL_ADDR_TRIM) ? trim_reg :
                  (reg_addr == `RTCCAL_ADDR_CTRL2) ? ctrl2_view : 8'h00;

  // Output stage; interrupt pins are open drain, active low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      clock_out_pin <= 1'b0;
      interrupt_pin_a_out <= 1'b0;
      interrupt_pin_a_oe <= 1'b0;
      interrupt_pin_b_out <= 1'b0;
      interrupt_pin_b_oe <= 1'b0;
      second_tick <= 1'b0;
    end
    else
    begin
      reg_rdata <= rd_mux;
      // R5 clock output gate
      clock_out_pin <= xtal_level_reg && !clkdis_reg && !xtal_fall;
      interrupt_pin_a_out <= 1'b0;
      // R6 periodic pin low
      interrupt_pin_a_oe <= pirq_reg || ala_reg;
      interrupt_pin_b_out <= 1'b0;
      interrupt_pin_b_oe <= alb_reg;
      second_tick <= tick;
    end
  end

endmodule

// >>> sim/rtccal_crystal_model.sv
// Crystal oscillator stand-in feeding the clock core
`timescale 1ns/10ps
module rtccal_crystal_model
#(
  parameter int HALF_NS = 200
)
(
  input wire logic run,
  output logic crystal_out
);
  // A stopped crystal holds its level, as a dead oscillator would
  initial
  begin
    crystal_out = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS);
      if (run)
        crystal_out = ~crystal_out;
    end
  end
endmodule

// >>> sim/rtccal_core_asserts.sv
// Port-level assertions for the clock core
`timescale 1ns/10ps
`include "rtccal_defs.svh"
module rtccal_core_asserts
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic periodic_event,
  input wire logic alarm_a_match,
  input wire logic alarm_b_match,
  input wire logic interrupt_pin_a_out,
  input wire logic interrupt_pin_a_oe,
  input wire logic interrupt_pin_b_out,
  input wire logic interrupt_pin_b_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire ctrl_wr = reg_write && reg_addr == `RTCCAL_ADDR_CTRL2;
  wire sec_sel = reg_addr == `RTCCAL_ADDR_SEC;

  pirq_pin_a: assert property (periodic_event |-> ##2 interrupt_pin_a_oe)
    else $error("pin A idle after periodic event");
  alarm_a_pin_a: assert property (alarm_a_match |-> ##2 interrupt_pin_a_oe)
    else $error("pin A idle after alarm A");
  alarm_b_pin_a: assert property (alarm_b_match |-> ##2 interrupt_pin_b_oe)
    else $error("pin B idle after alarm B");
  pin_b_cause_a: assert property ($rose(interrupt_pin_b_oe) |-> $past(alarm_b_match, 2))
    else $error("pin B driven without alarm B");
  pin_a_cause_a: assert property ($rose(interrupt_pin_a_oe) |->
    $past(periodic_event, 2) || $past(alarm_a_match, 2))
    else $error("pin A driven without cause");
  pin_b_release_a: assert property (ctrl_wr && !reg_wdata[0] && !alarm_b_match
    && !$past(alarm_b_match) |-> ##2 !interrupt_pin_b_oe)
    else $error("pin B held after clear");
  drain_only_a: assert property (!interrupt_pin_a_out && !interrupt_pin_b_out)
    else $error("interrupt pin driven high");
  sec_readback_a: assert property ((reg_write && sec_sel) ##1 sec_sel |=>
    reg_rdata == ($past(reg_wdata, 2) & `RTCCAL_MASK_SEC))
    else $error("seconds readback wrong");
  unmapped_zero_a: assert property (reg_addr inside {[4'h8:4'he]} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  wday_range_a: assert property (reg_addr == `RTCCAL_ADDR_WDAY |=>
    reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] != 3'h7)
    else $error("weekday out of range");

  cover property (ctrl_wr && reg_wdata[4]);
  cover property (alarm_a_match ##2 interrupt_pin_a_oe);
  cover property ($fell(interrupt_pin_b_oe));
endmodule

bind rtccal_core rtccal_core_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .periodic_event(periodic_event), .alarm_a_match(alarm_a_match),
  .alarm_b_match(alarm_b_match), .interrupt_pin_a_out(interrupt_pin_a_out),
  .interrupt_pin_a_oe(interrupt_pin_a_oe), .interrupt_pin_b_out(interrupt_pin_b_out),
  .interrupt_pin_b_oe(interrupt_pin_b_oe));

// >>> sim/test_rtc_calendar_and_status_flags.sv
// Self-checking bench for the clock core
`timescale 1ns/10ps
`include "rtccal_defs.svh"
module test_rtc_calendar_and_status_flags;
  typedef struct {logic h24; logic [55:0] set; logic [55:0] want;} rtccal_row_type;
  localparam logic [3:0] a_ctl = `RTCCAL_ADDR_CTRL2;
  localparam logic [3:0] a_trim = `RTCCAL_ADDR_TRIM;
  // Counts sec min hour wday day month year; adjust always fires
  // rows hold only valid times and dates
  rtccal_row_type rows [11] = '{
    '{1'b1, 56'h30_59_23_06_31_12_99, 56'h00_00_00_00_01_01_00},
    '{1'b1, 56'h29_59_23_06_31_12_99, 56'h00_59_23_06_31_12_99},
    '{1'b1, 56'h45_59_23_02_28_02_01, 56'h00_00_00_03_01_03_01},
    '{1'b1, 56'h45_59_23_02_28_02_04, 56'h00_00_00_03_29_02_04},
    '{1'b1, 56'h59_59_23_02_29_02_00, 56'h00_00_00_03_01_03_00},
    '{1'b1, 56'h30_59_23_04_30_04_10, 56'h00_00_00_05_01_05_10},
    '{1'b1, 56'h30_59_23_04_30_05_10, 56'h00_00_00_05_31_05_10},
    '{1'b1, 56'h30_59_09_01_15_06_10, 56'h00_00_10_01_15_06_10},
    '{1'b0, 56'h30_59_31_01_15_06_10, 56'h00_00_12_02_16_06_10},
    '{1'b0, 56'h30_59_11_01_15_06_10, 56'h00_00_32_01_15_06_10},
    '{1'b1, 56'h30_58_10_01_15_06_10, 56'h00_59_10_01_15_06_10}};
  // Address, write data, read-back
  logic [19:0] masks [7] = '{20'h0_a5_25, 20'h2_d2_12, 20'h3_fb_03, 20'h4_d5_15,
    20'h5_e9_09, 20'h8_55_00, 20'he_55_00};
  logic ref_clk, rst, crystal_in, crystal_run, reg_write;
  logic periodic_event, periodic_level_mode, alarm_a_match, alarm_b_match;
  logic clock_out_pin, interrupt_pin_a_out, interrupt_pin_a_oe;
  logic interrupt_pin_b_out, interrupt_pin_b_oe, second_tick;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  rtccal_row_type r;
  int fail_count, n_checks, cycles, edges;

  rtccal_core #(.HALT_CYCLES(50), .PRESCALE_32768(200), .PRESCALE_32000(160))
    u_dut (.ref_clk(ref_clk), .rst(rst),
    .crystal_in(crystal_in), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .periodic_event(periodic_event),
    .periodic_level_mode(periodic_level_mode), .alarm_a_match(alarm_a_match),
    .alarm_b_match(alarm_b_match), .clock_out_pin(clock_out_pin),
    .interrupt_pin_a_out(interrupt_pin_a_out), .interrupt_pin_a_oe(interrupt_pin_a_oe),
    .interrupt_pin_b_out(interrupt_pin_b_out), .interrupt_pin_b_oe(interrupt_pin_b_oe),
    .second_tick(second_tick));
  rtccal_crystal_model u_xtal (.run(crystal_run), .crystal_out(crystal_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic bad(input string msg);
    fail_count++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk8(input logic [3:0] a, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
      bad($sformatf("reg %h got %h want %h", a, got, exp));
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
      bad($sformatf("%s got %b", what, got));
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs about sixteen thousand cycles
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      bad("timeout");
      close_out();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_write <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1;
    chk8(a, reg_rdata, e);
  endtask

  task automatic pulse(input logic [2:0] ev);
    @(posedge ref_clk);
    {periodic_event, alarm_a_match, alarm_b_match} <= ev;
    @(posedge ref_clk);
    {periodic_event, alarm_a_match, alarm_b_match} <= 3'b000;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic count_edges(output int n);
    logic prev;
    n = 0;
    prev = clock_out_pin;
    repeat (400)
    begin
      @(posedge ref_clk);
      #1;
      if (clock_out_pin && !prev)
        n++;
      prev = clock_out_pin;
    end
  endtask

  // Cycles between two second pulses, less one
  task automatic tick_gap(output int n);
    repeat (2)
    begin
      n = 0;
      @(posedge ref_clk);
      #1;
      while (second_tick !== 1'b1 && n < 5000)
      begin
        @(posedge ref_clk);
        #1;
        n++;
      end
    end
  endtask

  initial
  begin
    rst = 1'b1;
    crystal_run = 1'b1;
    reg_addr = 4'h0;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    periodic_event = 1'b0;
    periodic_level_mode = 1'b0;
    alarm_a_match = 1'b0;
    alarm_b_match = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(a_ctl, 8'h10);
    rdchk(a_trim, 8'h00);
    wr(a_trim, 8'h85);
    rdchk(a_trim, 8'h00);
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h20);
    wr(a_trim, 8'h85);
    rdchk(a_trim, 8'h85);
    wr(a_trim, 8'h00);
    foreach (rows[i])
    begin
      r = rows[i];
      wr(a_ctl, {2'b00, r.h24, 5'h00});
      for (int k = 6; k >= 0; k--)
        wr(4'(k), r.set[8*(6-k) +: 8]);
      wr(a_ctl, {2'b00, r.h24, 5'h10});
      repeat (3) @(posedge ref_clk);
      for (int k = 0; k < 7; k++)
        rdchk(4'(k), r.want[8*(6-k) +: 8]);
    end
    // Adjust bit written as zero leaves seconds alone
    wr(4'h0, 8'h45);
    wr(a_ctl, 8'h20);
    repeat (3) @(posedge ref_clk);
    rdchk(4'h0, 8'h45);
    foreach (masks[i])
    begin
      wr(masks[i][19:16], masks[i][15:8]);
      rdchk(masks[i][19:16], masks[i][7:0]);
    end
    wr(a_trim, 8'h3f);
    count_edges(edges);
    chk1(edges >= 19 && edges <= 21, 1'b1, "clock out rate");
    wr(a_ctl, 8'h28);
    rdchk(a_ctl, 8'h28);
    count_edges(edges);
    chk1(edges == 0, 1'b1, "clock out disabled");
    crystal_run = 1'b0;
    repeat (80) @(posedge ref_clk);
    rdchk(a_ctl, 8'h30);
    rdchk(a_trim, 8'h00);
    crystal_run = 1'b1;
    repeat (30) @(posedge ref_clk);
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h20);
    pulse(3'b100);
    rdchk(a_ctl, 8'h24);
    chk1(interrupt_pin_a_oe, 1'b1, "pin A on");
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h24);
    @(posedge ref_clk);
    periodic_level_mode <= 1'b1;
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h20);
    chk1(interrupt_pin_a_oe, 1'b0, "pin A off");
    pulse(3'b100);
    rdchk(a_ctl, 8'h24);
    wr(a_ctl, 8'h20);
    pulse(3'b010);
    rdchk(a_ctl, 8'h22);
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h20);
    chk1(interrupt_pin_a_oe, 1'b0, "pin A off");
    pulse(3'b001);
    rdchk(a_ctl, 8'h21);
    chk1(interrupt_pin_b_oe, 1'b1, "pin B on");
    wr(a_ctl, 8'h20);
    rdchk(a_ctl, 8'h20);
    chk1(interrupt_pin_b_oe, 1'b0, "pin B off");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(a_ctl, 8'h10);
    wr(4'h0, 8'h59);
    tick_gap(edges);
    chk1(edges == 3999, 1'b1, "second period 32768");
    rdchk(4'h0, 8'h01);
    rdchk(4'h1, 8'h01);
    wr(a_ctl, 8'h20);
    wr(a_trim, 8'h80);
    tick_gap(edges);
    chk1(edges == 3199, 1'b1, "second period 32000");
    close_out();
  end
endmodule
